/* cce_eval.sv */
// Comparative contact evaluator inside the rung execution unit.
// Assumes the decoder presents one instruction with operand words already fetched.
//
// Notes on behaviour
// - Store-if-equal opens a rung or branch whose contact is true when the memory word equals operand B.
// - Store-if-not-equal opens a rung or branch whose closed contact is true when the words differ.
// - Or-if-equal ORs the rung result with the equality of the memory word and operand B.
// - Or-if-not-equal ORs the rung result with the inequality of the memory word and operand B.
// - And-if-equal ANDs the rung result with the equality of the memory word and operand B.
// - And-if-not-equal ANDs the rung result with the inequality of the memory word and operand B.
// - Compare-store-ge opens a rung or branch whose contact is true when A is at least B.
// - Compare-store-lt opens a rung or branch whose contact is true when A is below B.
// - Compare-or-lt ORs the rung result with A below B.
// - Compare-and-ge ANDs the rung result with A at least B.
// - Operand B is a memory word or an immediate constant from 0 to FFFF.
`timescale 1ns/1ns
`default_nettype none

module cce_eval
  import cce_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   MCLK,
  input  wire logic                   RESETN,
  input  wire logic                   CE,
  // Instruction from decoder
  input  wire logic                   RUNG_START,
  input  wire logic                   INSTR_VALID,
  input  wire cce_instr_t             INSTR,
  // Rung logic state
  output logic                        RLO,
  output logic                        STACK_TOP,
  output logic [CCE_DEPTH_W-1:0]      DEPTH,
  output logic                        CMP,
  output logic                        DONE,
  output logic                        ERR
);

  function automatic cce_kind_t cce_kind(input cce_op_t op);
    unique case (op)
      CCE_OP_STORE_IF_EQUAL, CCE_OP_STORE_IF_NOT_EQUAL,
      CCE_OP_COMPARE_STORE_GE, CCE_OP_COMPARE_STORE_LT:   cce_kind = CCE_K_STORE;
      CCE_OP_OR_IF_EQUAL, CCE_OP_OR_IF_NOT_EQUAL,
      CCE_OP_COMPARE_OR_LT:                                cce_kind = CCE_K_OR;
      CCE_OP_AND_IF_EQUAL, CCE_OP_AND_IF_NOT_EQUAL,
      CCE_OP_COMPARE_AND_GE:                               cce_kind = CCE_K_AND;
      default:                                             cce_kind = CCE_K_BAD;
    endcase
  endfunction

  // Unsigned compare; operands never sign extend
  function automatic logic cce_contact(input cce_op_t op, input logic [CCE_WORD_W-1:0] a,
                                       input logic [CCE_WORD_W-1:0] b);
    unique case (op)
      CCE_OP_STORE_IF_EQUAL, CCE_OP_OR_IF_EQUAL, CCE_OP_AND_IF_EQUAL:
        cce_contact = (a == b);
      CCE_OP_STORE_IF_NOT_EQUAL, CCE_OP_OR_IF_NOT_EQUAL, CCE_OP_AND_IF_NOT_EQUAL:
        cce_contact = (a != b);
      CCE_OP_COMPARE_STORE_GE, CCE_OP_COMPARE_AND_GE:
        cce_contact = (a >= b);
      CCE_OP_COMPARE_STORE_LT, CCE_OP_COMPARE_OR_LT:
        cce_contact = (a < b);
      default:
        cce_contact = 1'b0;
    endcase
  endfunction

  logic [CCE_WORD_W-1:0]   opnd_a;
  logic [CCE_WORD_W-1:0]   opnd_b;
  logic                    contact;
  cce_kind_t               kind;
  logic                    is_mag;
  logic                    bad;
  logic                    take;
  logic                    ok;
  logic                    open_eff;
  logic [CCE_DEPTH_W-1:0]  depth_eff;
  logic                    push;
  logic                    next_rlo;
  logic                    rung_open;
  logic [CCE_STACK_D-1:0]  stk;

  always_comb begin
    is_mag = (INSTR.op == CCE_OP_COMPARE_STORE_GE) || (INSTR.op == CCE_OP_COMPARE_STORE_LT) ||
             (INSTR.op == CCE_OP_COMPARE_OR_LT) || (INSTR.op == CCE_OP_COMPARE_AND_GE);
    unique case (INSTR.a_src)
      CCE_A_TMR: opnd_a = INSTR.a_tmr;
      CCE_A_CTR: opnd_a = INSTR.a_ctr;
      default:   opnd_a = INSTR.a_mem;
    endcase
    opnd_b = (INSTR.b_src == CCE_B_CONST) ? INSTR.b_const : INSTR.b_mem;
  end

  assign contact   = cce_contact(INSTR.op, opnd_a, opnd_b);
  assign kind      = cce_kind(INSTR.op);
  assign take      = CE && INSTR_VALID;
  // A rung start in the same cycle clears the stack before the instruction applies
  assign open_eff  = rung_open && !RUNG_START;
  assign depth_eff = RUNG_START ? CCE_DEPTH_RST : DEPTH;
  assign push      = (kind == CCE_K_STORE) && open_eff;

  // Refused: unknown opcode, timer/counter on an equality op, index past 77 octal,
  // series/parallel with no open rung, or a branch with the stack full
  always_comb begin
    bad = (kind == CCE_K_BAD) || (INSTR.a_src == 2'h3);
    if (INSTR.a_src != CCE_A_MEM) begin
      bad = bad || !is_mag || (INSTR.a_index > CCE_IDX_MAX);
    end
    if (kind != CCE_K_STORE) begin
      bad = bad || !open_eff;
    end
    if (push && (depth_eff == CCE_DEPTH_MAX)) begin
      bad = 1'b1;
    end
  end

  assign ok = take && !bad;

  always_comb begin
    unique case (kind)
      CCE_K_OR:  next_rlo = RLO | contact;
      CCE_K_AND: next_rlo = RLO & contact;
      default:   next_rlo = contact;
    endcase
  end

  // Result lands in the accumulator at the edge that takes the instruction
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      RLO <= CCE_RLO_RST;
      CMP <= 1'b0;
    end else if (CE && ok) begin
      RLO <= next_rlo;
      CMP <= contact;
    end
  end

  // Branch stack; pushing drops the deepest entry, guarded by the depth check
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      stk       <= '0;
      STACK_TOP <= 1'b0;
      DEPTH     <= CCE_DEPTH_RST;
      rung_open <= 1'b0;
    end else if (CE) begin
      if (ok && push) begin
        stk       <= {stk[CCE_STACK_D-2:0], RLO};
        STACK_TOP <= RLO;
        DEPTH     <= depth_eff + 4'h1;
        rung_open <= 1'b1;
      end else if (RUNG_START) begin
        stk       <= '0;
        STACK_TOP <= 1'b0;
        DEPTH     <= CCE_DEPTH_RST;
        rung_open <= ok;
      end else if (ok) begin
        rung_open <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      DONE <= 1'b0;
      ERR  <= 1'b0;
    end else if (CE) begin
      DONE <= take;
      ERR  <= take && bad;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_store_eq;
    ok && INSTR.op == CCE_OP_STORE_IF_EQUAL |=> RLO == ($past(opnd_a) == $past(opnd_b));
  endproperty
  a_store_eq: assert property (p_store_eq) else $error("store-if-equal result wrong");

  property p_store_ne;
    ok && INSTR.op == CCE_OP_STORE_IF_NOT_EQUAL |=> RLO == ($past(opnd_a) != $past(opnd_b));
  endproperty
  a_store_ne: assert property (p_store_ne) else $error("store-if-not-equal result wrong");

  property p_or_eq;
    ok && INSTR.op == CCE_OP_OR_IF_EQUAL |=> RLO == ($past(RLO) | ($past(opnd_a) == $past(opnd_b)));
  endproperty
  a_or_eq: assert property (p_or_eq) else $error("or-if-equal result wrong");

  property p_or_ne;
    ok && INSTR.op == CCE_OP_OR_IF_NOT_EQUAL |=> RLO == ($past(RLO) | ($past(opnd_a) != $past(opnd_b)));
  endproperty
  a_or_ne: assert property (p_or_ne) else $error("or-if-not-equal result wrong");

  property p_and_eq;
    ok && INSTR.op == CCE_OP_AND_IF_EQUAL |=> RLO == ($past(RLO) & ($past(opnd_a) == $past(opnd_b)));
  endproperty
  a_and_eq: assert property (p_and_eq) else $error("and-if-equal result wrong");

  property p_and_ne;
    ok && INSTR.op == CCE_OP_AND_IF_NOT_EQUAL |=> RLO == ($past(RLO) & ($past(opnd_a) != $past(opnd_b)));
  endproperty
  a_and_ne: assert property (p_and_ne) else $error("and-if-not-equal result wrong");

  property p_store_ge;
    ok && INSTR.op == CCE_OP_COMPARE_STORE_GE |=> RLO == ($past(opnd_a) >= $past(opnd_b)) && CMP == RLO;
  endproperty
  a_store_ge: assert property (p_store_ge) else $error("compare-store-ge result wrong");

  property p_store_lt;
    ok && INSTR.op == CCE_OP_COMPARE_STORE_LT |=> RLO == ($past(opnd_a) < $past(opnd_b));
  endproperty
  a_store_lt: assert property (p_store_lt) else $error("compare-store-lt result wrong");

  property p_or_lt;
    ok && INSTR.op == CCE_OP_COMPARE_OR_LT |=> RLO == ($past(RLO) | ($past(opnd_a) < $past(opnd_b)));
  endproperty
  a_or_lt: assert property (p_or_lt) else $error("compare-or-lt result wrong");

  property p_and_ge;
    ok && INSTR.op == CCE_OP_COMPARE_AND_GE |=> RLO == ($past(RLO) & ($past(opnd_a) >= $past(opnd_b)));
  endproperty
  a_and_ge: assert property (p_and_ge) else $error("compare-and-ge result wrong");

  property p_const_b;
    ok && INSTR.op == CCE_OP_COMPARE_STORE_GE && INSTR.b_src == CCE_B_CONST && INSTR.a_src == CCE_A_MEM
      |=> RLO == ($past(INSTR.a_mem) >= $past(INSTR.b_const));
  endproperty
  a_const_b: assert property (p_const_b) else $error("constant operand not used");

  property p_index_limit;
    take && INSTR.a_src == CCE_A_TMR && INSTR.a_index > CCE_IDX_MAX |=> ERR && $stable(RLO);
  endproperty
  a_index_limit: assert property (p_index_limit) else $error("timer index past limit accepted");

  property p_same_step;
    take |=> DONE && (ERR == !$past(ok));
  endproperty
  a_same_step: assert property (p_same_step) else $error("result not ready one edge after take");

  c_branch_push: cover property (ok && push ##1 DEPTH == 4'h1);
  c_timer_lt:    cover property (ok && INSTR.a_src == CCE_A_TMR && INSTR.op == CCE_OP_COMPARE_STORE_LT);
  c_overflow:    cover property (take && push && depth_eff == CCE_DEPTH_MAX);
  c_and_chain:   cover property (ok && INSTR.op == CCE_OP_STORE_IF_EQUAL ##1 ok && INSTR.op == CCE_OP_AND_IF_NOT_EQUAL);

endmodule

`default_nettype wire

/* cce_pkg.sv */
// Package for the comparative contact evaluator: widths, opcodes, operand sources,
// the instruction carrier and reset values.
// Assumes one scan clock domain; imported whole by the evaluator module.
package cce_pkg;

  localparam int          CCE_WORD_W    = 16;
  localparam int          CCE_STACK_D   = 8;
  localparam int          CCE_DEPTH_W   = 4;
  localparam int          CCE_IDX_W     = 7;
  localparam logic [6:0]  CCE_IDX_MAX   = 7'h3F;
  localparam logic [3:0]  CCE_DEPTH_MAX = 4'h8;
  localparam logic [3:0]  CCE_DEPTH_RST = 4'h0;
  localparam logic        CCE_RLO_RST   = 1'b0;

  typedef enum logic [3:0] {
    CCE_OP_STORE_IF_EQUAL     = 4'h0,
    CCE_OP_STORE_IF_NOT_EQUAL = 4'h1,
    CCE_OP_OR_IF_EQUAL        = 4'h2,
    CCE_OP_OR_IF_NOT_EQUAL    = 4'h3,
    CCE_OP_AND_IF_EQUAL       = 4'h4,
    CCE_OP_AND_IF_NOT_EQUAL   = 4'h5,
    CCE_OP_COMPARE_STORE_GE   = 4'h6,
    CCE_OP_COMPARE_STORE_LT   = 4'h7,
    CCE_OP_COMPARE_OR_LT      = 4'h8,
    CCE_OP_COMPARE_AND_GE     = 4'h9
  } cce_op_t;

  typedef enum logic [1:0] {
    CCE_K_STORE = 2'h0,
    CCE_K_OR    = 2'h1,
    CCE_K_AND   = 2'h2,
    CCE_K_BAD   = 2'h3
  } cce_kind_t;

  typedef enum logic [1:0] {
    CCE_A_MEM = 2'h0,
    CCE_A_TMR = 2'h1,
    CCE_A_CTR = 2'h2
  } cce_asrc_t;

  typedef enum logic {
    CCE_B_MEM   = 1'h0,
    CCE_B_CONST = 1'h1
  } cce_bsrc_t;

  typedef struct packed {
    cce_op_t                 op;
    cce_asrc_t               a_src;
    logic [CCE_IDX_W-1:0]    a_index;
    cce_bsrc_t               b_src;
    logic [CCE_WORD_W-1:0]   a_mem;
    logic [CCE_WORD_W-1:0]   a_tmr;
    logic [CCE_WORD_W-1:0]   a_ctr;
    logic [CCE_WORD_W-1:0]   b_mem;
    logic [CCE_WORD_W-1:0]   b_const;
  } cce_instr_t;

endpackage

/* test_comparative_contact_eval.sv */
// Self-checking bench for the comparative contact evaluator, with a reference rung model.
// Assumes cce_pkg and cce_eval are compiled first; the bench drives every port itself.
`timescale 1ns/1ns
`default_nettype none

module test_comparative_contact_eval;
  import cce_pkg::*;

  logic                   MCLK        = 1'b0;
  logic                   RESETN      = 1'b0;
  logic                   CE          = 1'b1;
  logic                   RUNG_START  = 1'b0;
  logic                   INSTR_VALID = 1'b0;
  cce_instr_t             INSTR       = '0;
  logic                   RLO;
  logic                   STACK_TOP;
  logic [CCE_DEPTH_W-1:0] DEPTH;
  logic                   CMP;
  logic                   DONE;
  logic                   ERR;
  int                     failures    = 0;
  int                     compares    = 0;
  int                     seed        = 74022;
  bit                     chk         = 1'b0;
  logic                   e_done, e_err, e_rlo, e_cmp, e_top, m_open;
  logic [3:0]             e_depth, op;
  logic [31:0]            r;

  cce_eval uut (.MCLK(MCLK), .RESETN(RESETN), .CE(CE), .RUNG_START(RUNG_START), .INSTR_VALID(INSTR_VALID),
                .INSTR(INSTR), .RLO(RLO), .STACK_TOP(STACK_TOP), .DEPTH(DEPTH), .CMP(CMP), .DONE(DONE), .ERR(ERR));

  always #20 MCLK = ~MCLK;

  task automatic wrap_up;
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp1(input string what, input logic [3:0] exp, input logic [3:0] seen);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Unselected sources carry the inverse, so a wrong operand pick shows up
  function automatic cce_instr_t mk(input logic [3:0] o, input logic [1:0] as, input logic [6:0] ix,
                                    input logic bs, input logic [15:0] av, input logic [15:0] bv);
    cce_instr_t i;
    i = cce_instr_t'({o, as, ix, bs, ~av, ~av, ~av, ~bv, ~bv});
    if (as == 2'h1)
      i.a_tmr = av;
    else if (as == 2'h2)
      i.a_ctr = av;
    else
      i.a_mem = av;
    if (bs)
      i.b_const = bv;
    else
      i.b_mem = bv;
    return i;
  endfunction

  // Model state commits only at the take edge, so the negedge compare never sees it early
  task automatic go(input cce_instr_t i, input logic rs);
    logic [15:0] a;
    logic [15:0] b;
    logic        c;
    logic        bad;
    logic        n_open;
    logic [3:0]  n_depth;
    int          k;
    INSTR       <= i;
    INSTR_VALID <= 1'b1;
    RUNG_START  <= rs;
    k       = (i.op inside {0, 1, 6, 7}) ? 0 : (i.op inside {2, 3, 8}) ? 1 : 2;
    n_open  = rs ? 1'b0 : m_open;
    n_depth = rs ? 4'h0 : e_depth;
    a       = (i.a_src == CCE_A_TMR) ? i.a_tmr : (i.a_src == CCE_A_CTR) ? i.a_ctr : i.a_mem;
    b       = (i.b_src == CCE_B_CONST) ? i.b_const : i.b_mem;
    bad     = i.op > 9 || i.a_src == 2'h3 || (i.a_src != 2'h0 && (i.op <= 5 || i.a_index > 63));
    bad     = bad || (k != 0 && !n_open) || (k == 0 && n_open && n_depth == 4'h8);
    c       = (i.op inside {0, 2, 4}) ? a == b : (i.op inside {1, 3, 5}) ? a != b : (i.op inside {6, 9}) ? a >= b : a < b;
    @(posedge MCLK);
    // Rung start clears the stack even when the instruction itself is refused
    if (rs && CE) begin
      m_open  = 1'b0;
      e_depth = 4'h0;
      e_top   = 1'b0;
    end
    e_done = 1'b1;
    e_err  = bad;
    if (!bad) begin
      e_cmp = c;
      if (k == 0) begin
        if (n_open) begin
          e_top = e_rlo;
          n_depth++;
        end
        e_rlo  = c;
        n_open = 1'b1;
      end else if (k == 1)
        e_rlo = e_rlo | c;
      else
        e_rlo = e_rlo & c;
      m_open  = n_open;
      e_depth = n_depth;
    end
  endtask

  task automatic idle(input int n);
    INSTR_VALID <= 1'b0;
    RUNG_START  <= 1'b0;
    @(posedge MCLK);
    e_done = 1'b0;
    e_err  = 1'b0;
    repeat (n - 1) @(posedge MCLK);
  endtask

  task automatic rst(input int n);
    RESETN      <= 1'b0;
    INSTR_VALID <= 1'b0;
    RUNG_START  <= 1'b0;
    @(posedge MCLK);
    {e_done, e_err, e_rlo, e_cmp, e_top, m_open} = 6'h00;
    e_depth = 4'h0;
    repeat (n - 1) @(posedge MCLK);
    RESETN <= 1'b1;
  endtask

  always @(negedge MCLK) begin
    if (chk) begin
      cmp1("DONE", e_done, DONE);
      cmp1("ERR", e_err, ERR);
      cmp1("RLO", e_rlo, RLO);
      cmp1("CMP", e_cmp, CMP);
      cmp1("DEPTH", e_depth, DEPTH);
      if (e_depth != 4'h0)
        cmp1("STACK_TOP", e_top, STACK_TOP);
    end
  end

  initial begin
    #(40 * 5000);
    failures++;
    wrap_up();
  end

  initial begin
    rst(3);
    chk = 1'b1;
    go(mk(4'h0, 2'h0, 7'h00, 1'b1, 16'h0005, 16'h0005), 1'b1);
    go(mk(4'h5, 2'h0, 7'h00, 1'b1, 16'h0005, 16'h0005), 1'b0);
    go(mk(4'h6, 2'h1, 7'h03, 1'b1, 16'h0009, 16'h0007), 1'b0);
    // Every op at A below, equal and above B, across the sign bit, after a true and a false store
    for (int o = 0; o < 10; o++)
      for (int d = 0; d < 6; d++) begin
        go(mk(4'h0, 2'h0, 7'h00, 1'b1, 16'h1234, d < 3 ? 16'h1234 : 16'h0000), 1'b1);
        go(mk(o[3:0], 2'h0, 7'h00, d[0], 16'h7FFF + 16'(d % 3), 16'h8000), 1'b0);
      end
    // Ten stores, the last one past the stack depth, counter index at its limit
    for (int j = 0; j < 10; j++)
      go(mk(4'h6 + 4'(j % 2), 2'h2, 7'h3F, 1'b0, 16'(j), 16'h0003), j == 0);
    go(mk(4'h9, 2'h1, 7'h40, 1'b1, 16'hFFFF, 16'h0000), 1'b0);
    go(mk(4'h2, 2'h1, 7'h01, 1'b1, 16'h0000, 16'h0000), 1'b0);
    idle(2);
    rst(1);
    go(mk(4'h2, 2'h0, 7'h00, 1'b1, 16'h0001, 16'h0001), 1'b0);
    // Clock enable low freezes every output, even with a request pending
    CE <= 1'b0;
    go(mk(4'h0, 2'h0, 7'h00, 1'b1, 16'h0000, 16'h0000), 1'b1);
    e_done = 1'b1;
    e_err  = 1'b1;
    e_rlo  = 1'b0;
    e_cmp  = 1'b0;
    m_open = 1'b0;
    repeat (2) @(posedge MCLK);
    CE <= 1'b1;
    idle(1);
    for (int n = 0; n < 400; n++) begin
      r  = $random(seed);
      op = r[3:0] % 4'hC;
      go(mk(op, r[5:4], r[12:6], r[13], {r[20] ? 12'hFFF : 12'h000, r[17:14]}, {r[21] ? 12'hFFF : 12'h000, r[25:22]}),
         r[26] && op inside {0, 1, 6, 7});
    end
    idle(2);
    wrap_up();
  end

endmodule

`default_nettype wire
